// ### include/chirp_pkg.sv
// package: constants and carrier types for the high-speed detection chirp controller
package chirp_pkg;
   // utmi line states
   localparam logic [1:0] LINE_SE0 = 2'h0;
   localparam logic [1:0] LINE_J   = 2'h1;
   localparam logic [1:0] LINE_K   = 2'h2;
   // utmi operating modes
   localparam logic [1:0] OPMODE_NORMAL  = 2'h0;
   localparam logic [1:0] OPMODE_NO_NRZI = 2'h2;
   // clock rate of the phy output clock
   localparam int CLK_MHZ = 100;
   // times in their printed units
   localparam int SETUP_CLOCKS_60  = 5;       // phy clocks between mode change and tx valid
   localparam int CHIRP_CLOCKS_60  = 66000;   // phy clocks for the device chirp
   localparam int FILTER_CLOCKS_60 = 165;     // phy clocks for a qualified chirp state
   localparam int FALLBACK_US      = 1500;    // wait after own chirp, inside 1.0ms..2.5ms
   localparam int TERM_US          = 10;      // time to switch terminations, under 500us
   localparam int SETUP_CYC  = (SETUP_CLOCKS_60 * CLK_MHZ + 59) / 60;
   localparam int CHIRP_CYC  = (CHIRP_CLOCKS_60 * CLK_MHZ + 59) / 60;
   localparam int FILTER_CYC = (FILTER_CLOCKS_60 * CLK_MHZ + 59) / 60;
   localparam int FALLBACK_CYC = FALLBACK_US * CLK_MHZ;
   localparam int TERM_CYC   = TERM_US * CLK_MHZ;
   localparam int CHIRPS_NEEDED = 6;          // k-j-k-j-k-j
   localparam int CNT_W = 20;
   // avalon register map (word addresses scaled to bytes)
   localparam logic [3:0] REG_CONTROL = 4'h0;
   localparam logic [3:0] REG_STATUS  = 4'h4;
   localparam int CTRL_START = 0;
   localparam int CTRL_ABORT = 1;
   localparam int STAT_BUSY  = 0;
   localparam int STAT_HS    = 1;
   localparam int STAT_FS    = 2;
   localparam int STAT_CNT   = 4;
   // utmi control group driven to the phy
   typedef struct packed {
      logic       xcvr_hs;     // 1 selects high-speed transceiver
      logic       term_hs;     // 1 selects high-speed terminations
      logic [1:0] opmode;
      logic       tx_valid;
      logic [7:0] tx_data;
   } utmi_ctrl_type;
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_SETUP  = 3'b001,
      ST_CHIRP  = 3'b010,
      ST_LISTEN = 3'b011,
      ST_TERM   = 3'b100,
      ST_HS     = 3'b101,
      ST_FS     = 3'b110
   } state_type;
endpackage : chirp_pkg

// ### hdl/chirp_ctrl.sv
// module: controller side of the high-speed detection chirp handshake
`timescale 1ns/1ns
module chirp_ctrl (
   input  wire logic                    clk,          // phy output clock domain
   input  wire logic                    rst,          // synchronous reset, high
   input  wire logic [3:0]              avs_address,  // byte address
   input  wire logic                    avs_read,     // read strobe
   input  wire logic                    avs_write,    // write strobe
   input  wire logic [31:0]             avs_writedata, // write data
   output logic [31:0]                  avs_readdata, // read data
   output logic                         avs_waitrequest, // stall
   input  wire logic [1:0]              line_state,   // utmi line state
   output chirp_pkg::utmi_ctrl_type     utmi_ctrl,    // utmi control group
   output logic                         bus_activity  // keeps inactivity timers clear
);
   import chirp_pkg::*;

   state_type            state_reg;
   logic [CNT_W-1:0]     timer_reg;
   logic [CNT_W-1:0]     filt_reg;
   logic [2:0]           chirp_cnt_reg;
   logic                 expect_k_reg;
   logic                 start_req_reg;
   logic                 abort_req_reg;
   logic                 done_hs_reg;
   logic                 done_fs_reg;
   logic                 ack_reg;
   logic                 sequence_done;
   logic                 qualified;
   logic [1:0]           want_state;

   // returns true when a line state is a chirp k or j
   function automatic logic is_chirp(input logic [1:0] ls);
      is_chirp = (ls == LINE_K) || (ls == LINE_J);
   endfunction : is_chirp

   assign want_state    = expect_k_reg ? LINE_K : LINE_J;
   assign qualified     = (filt_reg == CNT_W'(FILTER_CYC - 1)) && (line_state == want_state);
   assign sequence_done = qualified && (chirp_cnt_reg == 3'(CHIRPS_NEEDED - 1));

   // avalon slave: one wait cycle on every access keeps the answer registered
   always_ff @(posedge clk) begin
      if (rst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (avs_read || avs_write) && !ack_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && !ack_reg);
      end
   end

   // control writes raise one-shot requests taken by the state machine
   always_ff @(posedge clk) begin
      if (rst) begin
         start_req_reg <= 1'b0;
         abort_req_reg <= 1'b0;
      end else begin
         start_req_reg <= 1'b0;
         abort_req_reg <= 1'b0;
         if (avs_write && ack_reg && avs_address == REG_CONTROL) begin
            start_req_reg <= avs_writedata[CTRL_START];
            abort_req_reg <= avs_writedata[CTRL_ABORT];
         end
      end
   end

   // status read; unmapped addresses read zero
   always_ff @(posedge clk) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !ack_reg) begin
         avs_readdata <= 32'h0000_0000;
         if (avs_address == REG_STATUS) begin
            avs_readdata[STAT_BUSY] <= (state_reg != ST_IDLE) && (state_reg != ST_HS)
                                       && (state_reg != ST_FS);
            avs_readdata[STAT_HS]   <= done_hs_reg;
            avs_readdata[STAT_FS]   <= done_fs_reg;
            avs_readdata[STAT_CNT +: 3] <= chirp_cnt_reg;
         end
      end
   end

   // handshake sequencer
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         timer_reg <= '0;
      end else if (abort_req_reg) begin
         state_reg <= ST_IDLE;
         timer_reg <= '0;
      end else begin
         timer_reg <= timer_reg + 1'b1;
         unique case (state_reg)
            ST_IDLE, ST_HS, ST_FS: begin
               if (start_req_reg) begin
                  state_reg <= ST_SETUP;
                  timer_reg <= '0;
               end
            end
            ST_SETUP: begin
               if (timer_reg == CNT_W'(SETUP_CYC - 1)) begin
                  state_reg <= ST_CHIRP;
                  timer_reg <= '0;
               end
            end
            ST_CHIRP: begin
               if (timer_reg == CNT_W'(CHIRP_CYC - 1)) begin
                  state_reg <= ST_LISTEN;
                  timer_reg <= '0;
               end
            end
            ST_LISTEN: begin
               if (sequence_done) begin
                  state_reg <= ST_TERM;
                  timer_reg <= '0;
               end else if (timer_reg == CNT_W'(FALLBACK_CYC - 1)) begin
                  state_reg <= ST_FS;
                  timer_reg <= '0;
               end
            end
            ST_TERM: begin
               if (timer_reg == CNT_W'(TERM_CYC - 1)) begin
                  state_reg <= ST_HS;
                  timer_reg <= '0;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // chirp qualification filter and counter, running from own chirp end on line state
   always_ff @(posedge clk) begin
      if (rst || !(state_reg == ST_CHIRP || state_reg == ST_LISTEN)) begin
         filt_reg      <= '0;
         chirp_cnt_reg <= 3'h0;
         expect_k_reg  <= 1'b1;
      end else if (state_reg == ST_CHIRP) begin
         filt_reg      <= '0; // own k on the bus is not a host chirp
         chirp_cnt_reg <= 3'h0;
         expect_k_reg  <= 1'b1;
      end else if (line_state == want_state) begin
         // count up to the filter length, then clear; a host state of 40-60us far exceeds it
         if (filt_reg != CNT_W'(FILTER_CYC - 1)) begin
            filt_reg <= filt_reg + 1'b1;
         end else if (qualified) begin
            filt_reg      <= '0;
            expect_k_reg  <= !expect_k_reg;
            // the sixth state hands over to the sequencer, so the count stops at five
            chirp_cnt_reg <= sequence_done ? chirp_cnt_reg : chirp_cnt_reg + 1'b1;
         end
      end else if (is_chirp(line_state) && filt_reg == '0) begin
         filt_reg <= '0; // tail of the previous state still showing
      end else begin
         filt_reg      <= '0;
         chirp_cnt_reg <= 3'h0;
         expect_k_reg  <= 1'b1;
      end
   end

   // utmi outputs, registered
   always_ff @(posedge clk) begin
      if (rst) begin
         utmi_ctrl <= '{xcvr_hs: 1'b0, term_hs: 1'b0, opmode: OPMODE_NORMAL,
                        tx_valid: 1'b0, tx_data: 8'h00};
      end else begin
         unique case (state_reg)
            ST_SETUP: begin
               utmi_ctrl <= '{xcvr_hs: 1'b1, term_hs: 1'b0, opmode: OPMODE_NO_NRZI,
                              tx_valid: 1'b0, tx_data: 8'h00};
            end
            ST_CHIRP: begin
               utmi_ctrl <= '{xcvr_hs: 1'b1, term_hs: 1'b0, opmode: OPMODE_NO_NRZI,
                              tx_valid: 1'b1, tx_data: 8'h00};
            end
            ST_LISTEN: begin
               utmi_ctrl <= '{xcvr_hs: 1'b1, term_hs: 1'b0, opmode: OPMODE_NORMAL,
                              tx_valid: 1'b0, tx_data: 8'h00};
            end
            ST_TERM, ST_HS: begin
               utmi_ctrl <= '{xcvr_hs: 1'b1, term_hs: 1'b1, opmode: OPMODE_NORMAL,
                              tx_valid: 1'b0, tx_data: 8'h00};
            end
            default: begin
               utmi_ctrl <= '{xcvr_hs: 1'b0, term_hs: 1'b0, opmode: OPMODE_NORMAL,
                              tx_valid: 1'b0, tx_data: 8'h00};
            end
         endcase
      end
   end

   // result flags, sticky until the next start
   always_ff @(posedge clk) begin
      if (rst || start_req_reg) begin
         done_hs_reg <= 1'b0;
         done_fs_reg <= 1'b0;
      end else begin
         if (state_reg == ST_HS) done_hs_reg <= 1'b1;
         if (state_reg == ST_FS) done_fs_reg <= 1'b1;
      end
   end

   // host chirps seen in ST_LISTEN are activity; the idle timers elsewhere must not run
   always_ff @(posedge clk) begin
      if (rst) begin
         bus_activity <= 1'b0;
      end else begin
         bus_activity <= (state_reg == ST_LISTEN) && is_chirp(line_state);
      end
   end

   // line run length kept apart from the filter, so that the filter is checked from outside
   logic [CNT_W-1:0]     line_run_reg;
   logic [1:0]           line_prev_reg;
   always_ff @(posedge clk) begin
      if (rst) begin
         line_run_reg  <= '0;
         line_prev_reg <= LINE_SE0;
      end else begin
         line_prev_reg <= line_state;
         if (line_state != line_prev_reg) begin
            line_run_reg <= CNT_W'(1);
         end else if (line_run_reg != '1) begin
            line_run_reg <= line_run_reg + 1'b1;
         end
      end
   end

   // assertions
   property p_setup_gap;
      @(posedge clk) disable iff (rst)
         $rose(utmi_ctrl.xcvr_hs) |-> !utmi_ctrl.tx_valid [*5];
   endproperty
   a_setup_gap: assert property (p_setup_gap) else $error("tx valid too soon");

   property p_chirp_mode;
      @(posedge clk) disable iff (rst)
         utmi_ctrl.tx_valid |-> utmi_ctrl.xcvr_hs && utmi_ctrl.opmode == OPMODE_NO_NRZI
                                && utmi_ctrl.tx_data == 8'h00;
   endproperty
   a_chirp_mode: assert property (p_chirp_mode) else $error("bad chirp mode");

   property p_start_fs;
      @(posedge clk) disable iff (rst)
         (state_reg == ST_SETUP && timer_reg == '0) |-> !utmi_ctrl.term_hs;
   endproperty
   a_start_fs: assert property (p_start_fs) else $error("not full speed at start");

   property p_chirp_len;
      @(posedge clk) disable iff (rst)
         (state_reg == ST_CHIRP) |-> timer_reg < CNT_W'(CHIRP_CYC);
   endproperty
   a_chirp_len: assert property (p_chirp_len) else $error("chirp too long");

   property p_chirp_end;
      @(posedge clk) disable iff (rst || abort_req_reg)
         (state_reg == ST_CHIRP && timer_reg == CNT_W'(CHIRP_CYC - 1))
            |=> state_reg == ST_LISTEN ##1 !utmi_ctrl.tx_valid;
   endproperty
   a_chirp_end: assert property (p_chirp_end) else $error("chirp did not end");

   property p_term_hs;
      @(posedge clk) disable iff (rst || abort_req_reg)
         sequence_done && state_reg == ST_LISTEN |-> ##[1:2] utmi_ctrl.term_hs;
   endproperty
   a_term_hs: assert property (p_term_hs) else $error("terminations late");

   property p_fallback;
      @(posedge clk) disable iff (rst)
         $rose(state_reg == ST_FS) |=> !utmi_ctrl.xcvr_hs;
   endproperty
   a_fallback: assert property (p_fallback) else $error("no return to full speed");

   property p_count_bound;
      @(posedge clk) disable iff (rst)
         chirp_cnt_reg < 3'(CHIRPS_NEEDED);
   endproperty
   a_count_bound: assert property (p_count_bound) else $error("count overflow");

   property p_reset_count;
      @(posedge clk) disable iff (rst || abort_req_reg)
         (state_reg == ST_LISTEN && line_state == LINE_SE0 && chirp_cnt_reg != 3'h0)
            |=> chirp_cnt_reg == 3'h0;
   endproperty
   a_reset_count: assert property (p_reset_count) else $error("count kept");

   property p_setup_mode;
      @(posedge clk) disable iff (rst)
         $rose(utmi_ctrl.tx_valid) |-> $past(utmi_ctrl.xcvr_hs, SETUP_CYC)
                                       && $past(utmi_ctrl.opmode, SETUP_CYC) == OPMODE_NO_NRZI;
   endproperty
   a_setup_mode: assert property (p_setup_mode) else $error("mode not set before tx valid");

   property p_listen_quiet;
      @(posedge clk) disable iff (rst)
         (state_reg == ST_LISTEN) |=> !utmi_ctrl.tx_valid && utmi_ctrl.xcvr_hs;
   endproperty
   a_listen_quiet: assert property (p_listen_quiet) else $error("bus not free for host");

   property p_filter_clear;
      @(posedge clk) disable iff (rst)
         (state_reg == ST_CHIRP) |=> filt_reg == '0 && chirp_cnt_reg == 3'h0 && expect_k_reg;
   endproperty
   a_filter_clear: assert property (p_filter_clear) else $error("own chirp counted");

   property p_qualify;
      @(posedge clk) disable iff (rst)
         qualified |-> line_state == line_prev_reg
                       && line_run_reg >= CNT_W'(FILTER_CYC - 1);
   endproperty
   a_qualify: assert property (p_qualify) else $error("chirp state counted too soon");

   property p_fallback_time;
      @(posedge clk) disable iff (rst)
         $rose(state_reg == ST_FS) |-> $past(state_reg) == ST_LISTEN
                                       && $past(timer_reg) == CNT_W'(FALLBACK_CYC - 1);
   endproperty
   a_fallback_time: assert property (p_fallback_time) else $error("fallback mistimed");

   property p_no_early_term;
      @(posedge clk) disable iff (rst)
         $rose(utmi_ctrl.term_hs) |-> $past(state_reg) == ST_TERM;
   endproperty
   a_no_early_term: assert property (p_no_early_term) else $error("terminations unasked");

   property p_hs_hold;
      @(posedge clk) disable iff (rst)
         (state_reg == ST_HS) |-> utmi_ctrl.term_hs && utmi_ctrl.xcvr_hs;
   endproperty
   a_hs_hold: assert property (p_hs_hold) else $error("hs setting lost");

   property p_activity;
      @(posedge clk) disable iff (rst)
         bus_activity |-> $past(state_reg) == ST_LISTEN;
   endproperty
   a_activity: assert property (p_activity) else $error("activity outside listening");

   c_chirp: cover property (@(posedge clk) disable iff (rst) $rose(utmi_ctrl.tx_valid));
   c_break: cover property (@(posedge clk) disable iff (rst)
      state_reg == ST_LISTEN && line_state == LINE_SE0 && chirp_cnt_reg != 3'h0);
   c_hs: cover property (@(posedge clk) disable iff (rst) $rose(state_reg == ST_HS));
   c_fs: cover property (@(posedge clk) disable iff (rst) $rose(state_reg == ST_FS));
endmodule : chirp_ctrl

// ### sim/phy_host_model.sv
// behavioural phy plus host port model for the chirp handshake
`timescale 1ns/1ns
module phy_host_model #(
   parameter int GAP_CYC  = 9000,  // host reply delay after device chirp
   parameter int HOLD_CYC = 4000   // host chirp state length, 40us at 100MHz
) (
   input  wire logic                    clk,          // controller clock
   input  wire chirp_pkg::utmi_ctrl_type utmi_ctrl,   // utmi control group
   input  wire logic [3:0]              host_chirps,  // states sent, 0 for an fs host
   input  wire logic [3:0]              break_at,     // state replaced by se0
   output logic [1:0]                   line_state,   // utmi line state
   output logic                         pullup_on,    // dp pull-up
   output logic                         hs_default    // phy in hs default state
);
   import chirp_pkg::*;
   logic       dev_k;
   logic [1:0] host_line;
   // the device chirp only shows as k with nrzi off and all-zero data
   assign dev_k = utmi_ctrl.tx_valid && utmi_ctrl.xcvr_hs && utmi_ctrl.opmode == OPMODE_NO_NRZI
                  && utmi_ctrl.tx_data == 8'h00;
   assign line_state = dev_k ? LINE_K : host_line;
   // pull-up stays on until hs terminations are chosen
   assign pullup_on  = !utmi_ctrl.term_hs;
   assign hs_default = utmi_ctrl.term_hs && utmi_ctrl.xcvr_hs;
   // host answers every device chirp; an fs host stays silent at se0
   initial begin
      host_line = LINE_SE0;
      forever begin
         @(negedge utmi_ctrl.tx_valid);
         repeat (GAP_CYC) @(posedge clk);
         for (int i = 0; i < int'(host_chirps); i++) begin
            host_line <= (i == int'(break_at)) ? LINE_SE0 : (i[0] ? LINE_J : LINE_K);
            repeat (HOLD_CYC) @(posedge clk);
         end
         host_line <= LINE_SE0;
      end
   end
endmodule : phy_host_model

// ### sim/hs_detection_chirp_handshake_tb_top.sv
// bench for the chirp handshake controller
`timescale 1ns/1ns
module hs_detection_chirp_handshake_tb_top;
   import chirp_pkg::*;
   logic          clk, rst, avs_read, avs_write, avs_waitrequest;
   logic          bus_activity, pullup_on, hs_default;
   logic [3:0]    avs_address, host_chirps, break_at;
   logic [31:0]   avs_writedata, avs_readdata, rd;
   logic [1:0]    line_state;
   utmi_ctrl_type utmi_ctrl;
   int            err_count, cmp_count, n;

   chirp_ctrl u_chirp_ctrl (.clk(clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .line_state(line_state), .utmi_ctrl(utmi_ctrl), .bus_activity(bus_activity));
   phy_host_model u_phy_host_model (.clk(clk), .utmi_ctrl(utmi_ctrl),
      .host_chirps(host_chirps), .break_at(break_at), .line_state(line_state),
      .pullup_on(pullup_on), .hs_default(hs_default));

   task end_sim;
      $display("checks %0d errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim

   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : chk

   // one avalon transfer; held until waitrequest is sampled low
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'h0) begin
         @(posedge clk);
      end
      rd = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
   endtask : bus

   // counts cycles until a utmi control bit reaches v: 0 xcvr, 1 tx valid, 2 term
   task wait_ctl(input int sel, input logic v, input int lim);
      n = 0;
      while ((sel == 0 ? utmi_ctrl.xcvr_hs : sel == 1 ? utmi_ctrl.tx_valid : utmi_ctrl.term_hs)
             !== v && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk("wait_done", n < lim, 1'h1);
   endtask : wait_ctl

   task run_chirp;
      bus(1'h1, REG_CONTROL, 32'h0000_0001);
      wait_ctl(0, 1'h1, 50);
      chk("opmode", utmi_ctrl.opmode, OPMODE_NO_NRZI);
      wait_ctl(1, 1'h1, 50);
      chk("setup_ok", n >= SETUP_CYC, 1'h1);
      chk("tx_data", utmi_ctrl.tx_data, 8'h00);
      chk("term_fs", utmi_ctrl.term_hs, 1'h0);
      wait_ctl(1, 1'h0, 200000);
      chk("chirp_len", n, CHIRP_CYC);
   endtask : run_chirp

   // silent host: fall back to full speed
   task t_fs;
      run_chirp;
      wait_ctl(0, 1'h0, 300000);
      chk("fallback_ok", n >= 100000 && n <= 250000, 1'h1);
      chk("term_stay_fs", utmi_ctrl.term_hs, 1'h0);
      bus(1'h0, REG_STATUS, 32'h0000_0000);
      chk("fs_done", rd[STAT_FS], 1'h1);
      chk("fs_status", rd, 32'h1 << STAT_FS);
   endtask : t_fs

   // hs host: k-j-k, se0 break, then a full k-j-k-j-k-j run
   task t_hs;
      host_chirps <= 4'hA;
      break_at <= 4'h3;
      run_chirp;
      repeat (44800) @(negedge clk);
      chk("term_early", utmi_ctrl.term_hs, 1'h0);
      chk("activity", bus_activity, 1'h1);
      chk("pullup", pullup_on, 1'h1);
      bus(1'h0, REG_STATUS, 32'h0000_0000);
      chk("busy_cnt", rd, (32'h1 << STAT_BUSY) | (32'(CHIRPS_NEEDED - 1) << STAT_CNT));
      wait_ctl(2, 1'h1, 60000);
      chk("term_ok", n >= 195 + FILTER_CYC && n <= 50200 + FILTER_CYC, 1'h1);
      chk("hs_state", hs_default, 1'h1);
      chk("pullup_off", pullup_on, 1'h0);
      // the hs result is only posted once the termination wait is over
      repeat (TERM_CYC + 2) @(posedge clk);
      bus(1'h0, REG_STATUS, 32'h0000_0000);
      chk("hs_done", rd[STAT_HS], 1'h1);
      chk("hs_status", rd, 32'h1 << STAT_HS);
   endtask : t_hs

   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   // watchdog well past the expected 4.2ms run
   initial begin
      #6000000;
      err_count++;
      end_sim;
   end

   initial begin
      rst = 1'h1;
      avs_read = 1'h0;
      avs_write = 1'h0;
      avs_address = 4'h0;
      avs_writedata = 32'h0000_0000;
      host_chirps = 4'h0;
      break_at = 4'hF;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      chk("ctrl_rst", utmi_ctrl, {1'h0, 1'h0, OPMODE_NORMAL, 1'h0, 8'h00});
      bus(1'h0, 4'h8, 32'h0000_0000);
      chk("unmapped", rd, 32'h0000_0000);
      bus(1'h0, REG_STATUS, 32'h0000_0000);
      chk("status_rst", rd, 32'h0000_0000);
      t_fs;
      t_hs;
      end_sim;
   end
endmodule : hs_detection_chirp_handshake_tb_top
